// *** pllcg_pkg.sv ***
`default_nettype none
package pllcg_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_PLL = 3'h0;
    localparam logic [2:0] ADDR_PCC = 3'h1;
    localparam logic [2:0] ADDR_MODE = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h3;
    localparam logic [2:0] ADDR_PORT = 3'h4;
    // ------------------------------------------------------------
    // PLL control fields
    // ------------------------------------------------------------
    localparam logic [7:0] PLL_RESET = 8'h01;
    localparam logic [7:0] PLL_WMASK = 8'h0F;
    localparam int PLL_RUN_POS = 0;
    localparam int PLL_SEL_POS = 1;
    // ------------------------------------------------------------
    // Processor clock control fields
    // ------------------------------------------------------------
    localparam logic [7:0] PCC_RESET = 8'h03;
    localparam int CK3_POS = 3;
    localparam int CLS_POS = 4;
    localparam int MAIN_FEEDBACK_RESISTOR_OFF_POS = 5;
    localparam int MCK_POS = 6;
    localparam int FRC_POS = 7;
    localparam logic [2:0] CK_PROHIB = 3'h6;
    localparam logic [2:0] CK_MAX = 3'h5;
    // ------------------------------------------------------------
    // Standby modes and port control
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_IDLE = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h3;
    localparam int PORT_CLOCK_OUTPUT_PIN_POS = 0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PLL_MULT = 4;
    localparam int PLL_LOCK_US = 200;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int OST_CYC = 1024;
    localparam int SUB_DIV = 3052;
    localparam int CNT_W = 24;
    typedef enum logic [2:0] {PW_OST, PW_RUN, PW_HALT, PW_IDLE, PW_STOP}
        pllcg_pwr_e;
endpackage : pllcg_pkg
`default_nettype wire

// *** pllcg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Clock output pin shows system clock when running, low when stopped.
// - After reset clock output pin floats until port set to clock output.
// - Clock output source is system clock picked by selection field.
// - Field 0-5 divides main clock, default /8, 011x banned, 1xxx subclock.
// - PLL mode gives four times oscillator rate; clock-through passes it.
// - PLL control resets to 01: PLL running, clock-through selected.
// - Stabilisation is counted even with external clock; resistor off.
// - Main oscillator stops in reset, STOP, and subclock with stop bit.
// - System clock runs only in HALT and run modes.
// - Peripheral clocks run with system clock and main oscillator only.
// - Ring-oscillator watchdog clock runs except in reset; subclock always runs.
// - CPU clock runs only in run mode, main or subclock.
module pllcg_top #(
    parameter int LOCK_CYC = pllcg_pkg::PLL_LOCK_CYC,
    parameter int OST_CYCLES = pllcg_pkg::OST_CYC,
    parameter int SUB_CYCLES = pllcg_pkg::SUB_DIV
) (
    input wire logic I_MCLK, // Master clock
    input wire logic I_RST_B, // Sync reset, active low
    input wire logic [pllcg_pkg::ADDR_W-1:0] I_ADDR, // Register address
    input wire logic [7:0] I_WDATA, // Write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    input wire logic I_WAKE, // Standby release pin
    output logic [7:0] O_RDATA, // Read data
    output logic O_CPU_CLK_EN, // CPU clock gate
    output logic O_SYS_CLK_EN, // System clock gate
    output logic O_PERIPH_CLK_EN, // Prescaler clock gate
    output logic O_MAIN_OSC_EN, // Main oscillator run
    output logic O_SUB_OSC_EN, // Subclock oscillator run
    output logic O_WDT_INT_CLK_EN, // Ring oscillator watchdog clock
    output logic O_PLL_EN, // PLL run
    output logic O_FEEDBACK_OFF, // Main feedback resistor off
    output logic O_SYS_TICK, // One pulse per system clock
    output logic O_CLOCK_OUTPUT_PIN, // Clock output pin level
    output logic O_CLOCK_OUTPUT_PIN_OE_B // Clock output enable, low drives
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] pll;
        logic [7:0] processor_clock_control;
        logic port_fn;
        pllcg_pkg::pllcg_pwr_e pw;
        logic [15:0] ost;
        logic [1:0] osc_cnt;
        logic [pllcg_pkg::CNT_W-1:0] lock_cnt;
        logic locked;
        logic sel_eff;
        logic [4:0] div_cnt;
        logic [15:0] sub_cnt;
        logic wake1;
        logic wake2;
        logic clock_output_pin;
        logic sys_tick;
        logic cpu_en;
        logic sys_en;
        logic per_en;
        logic main_en;
        logic wdt_en;
        logic [7:0] rdata;
    } pllcg_st_s;

    pllcg_st_s q;
    pllcg_st_s d;
    logic main_run;
    logic osc_tick;
    logic fxx_tick;
    logic sub_tick;
    logic sys_run;
    logic cpu_clock_status_bit;
    logic [4:0] div_last;

    // Divide ratio minus one for a selection code
    function automatic logic [4:0] pllcg_div(input logic [2:0] ck);
        pllcg_div = 5'((6'h01 << ck) - 6'h01);
    endfunction : pllcg_div

    // ------------------------------------------------------------
    // Clock enables
    // ------------------------------------------------------------
    // Main stop bit only bites once the CPU really runs on subclock
    // main osc stop
    assign cpu_clock_status_bit = q.processor_clock_control[pllcg_pkg::CLS_POS];
    assign main_run = (q.pw != pllcg_pkg::PW_STOP) &&
        !(cpu_clock_status_bit && q.processor_clock_control[pllcg_pkg::MCK_POS]);
    assign osc_tick = main_run && (q.osc_cnt == 2'h0);
    assign fxx_tick = q.sel_eff ? main_run : osc_tick;
    assign sub_tick = (q.sub_cnt == 16'h0000);
    assign sys_run = (q.pw == pllcg_pkg::PW_RUN) ||
        (q.pw == pllcg_pkg::PW_HALT);
    assign div_last = pllcg_div(q.processor_clock_control[2:0]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Registers, standby sequencing, dividers and gates
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        d.wake1 = I_WAKE;
        d.wake2 = q.wake1;
        d.sub_cnt = sub_tick ? 16'(SUB_CYCLES - 1) : q.sub_cnt - 16'h0001;
        d.osc_cnt = main_run ? q.osc_cnt + 2'h1 : 2'h0;
        if (I_WR) begin
            unique case (I_ADDR)
                pllcg_pkg::ADDR_PLL: d.pll = I_WDATA & pllcg_pkg::PLL_WMASK;
                pllcg_pkg::ADDR_PCC: begin
                    d.processor_clock_control[pllcg_pkg::FRC_POS] = I_WDATA[pllcg_pkg::FRC_POS];
                    d.processor_clock_control[pllcg_pkg::MCK_POS] = I_WDATA[pllcg_pkg::MCK_POS];
                    d.processor_clock_control[pllcg_pkg::MAIN_FEEDBACK_RESISTOR_OFF_POS] = I_WDATA[pllcg_pkg::MAIN_FEEDBACK_RESISTOR_OFF_POS];
                    d.processor_clock_control[pllcg_pkg::CK3_POS] = I_WDATA[pllcg_pkg::CK3_POS];
                    if (I_WDATA[2:0] <= pllcg_pkg::CK_MAX) begin
                        d.processor_clock_control[2:0] = I_WDATA[2:0];
                    end
                end
                pllcg_pkg::ADDR_MODE: begin
                    if (q.pw == pllcg_pkg::PW_RUN) begin
                        unique case (I_WDATA[1:0])
                            pllcg_pkg::MODE_HALT: d.pw = pllcg_pkg::PW_HALT;
                            pllcg_pkg::MODE_IDLE: d.pw = pllcg_pkg::PW_IDLE;
                            pllcg_pkg::MODE_STOP: d.pw = pllcg_pkg::PW_STOP;
                            default: d.pw = pllcg_pkg::PW_RUN;
                        endcase
                    end
                end
                pllcg_pkg::ADDR_PORT:
                    d.port_fn = I_WDATA[pllcg_pkg::PORT_CLOCK_OUTPUT_PIN_POS];
                default: d.rdata = 8'h00;
            endcase
        end
        if (I_RD) begin
            unique case (I_ADDR)
                pllcg_pkg::ADDR_PLL: d.rdata = q.pll;
                pllcg_pkg::ADDR_PCC: d.rdata = q.processor_clock_control;
                pllcg_pkg::ADDR_MODE: d.rdata = {5'h00, q.pw};
                pllcg_pkg::ADDR_STAT:
                    d.rdata = {5'h00, cpu_clock_status_bit, q.sel_eff, q.locked};
                pllcg_pkg::ADDR_PORT: d.rdata = {7'h00, q.port_fn};
                default: d.rdata = 8'h00;
            endcase
        end
        // Subclock status follows its select bit on a subclock edge
        if (sub_tick) begin
            d.processor_clock_control[pllcg_pkg::CLS_POS] = q.processor_clock_control[pllcg_pkg::CK3_POS];
        end
        // Wake from standby; STOP and main clock IDLE need a fresh count
        // count always
        if (q.wake2) begin
            unique case (q.pw)
                pllcg_pkg::PW_HALT: d.pw = pllcg_pkg::PW_RUN;
                pllcg_pkg::PW_IDLE: begin
                    d.pw = cpu_clock_status_bit ? pllcg_pkg::PW_RUN : pllcg_pkg::PW_OST;
                    d.ost = 16'(OST_CYCLES - 1);
                end
                pllcg_pkg::PW_STOP: begin
                    d.pw = pllcg_pkg::PW_OST;
                    d.ost = 16'(OST_CYCLES - 1);
                end
                default: d.pw = q.pw;
            endcase
        end
        if (q.pw == pllcg_pkg::PW_OST) begin
            if (q.ost == 16'h0000) begin
                d.pw = pllcg_pkg::PW_RUN;
            end else begin
                d.ost = q.ost - 16'h0001;
            end
        end
        // Lock status for software polling; PLL dies with its source
        if (q.pll[pllcg_pkg::PLL_RUN_POS] && main_run) begin
            if (q.lock_cnt == pllcg_pkg::CNT_W'(LOCK_CYC - 1)) begin
                d.locked = 1'b1;
            end else begin
                d.lock_cnt = q.lock_cnt + 1'b1;
            end
        end else begin
            d.lock_cnt = '0;
            d.locked = 1'b0;
        end
        // Source swaps on an oscillator edge or while main is stopped, so both clocks
        // line up and no phase is cut short
        // aligned switch
        if (osc_tick || !main_run) begin
            d.sel_eff = q.pll[pllcg_pkg::PLL_SEL_POS] &&
                q.pll[pllcg_pkg::PLL_RUN_POS] && main_run;
        end
        d.sys_tick = 1'b0;
        if (cpu_clock_status_bit) begin
            d.sys_tick = sub_tick;
            d.div_cnt = 5'h00;
        end else if (fxx_tick) begin
            d.sys_tick = (q.div_cnt >= div_last);
            d.div_cnt = d.sys_tick ? 5'h00 : q.div_cnt + 5'h01;
        end
        d.sys_tick = d.sys_tick && sys_run;
        d.clock_output_pin = sys_run ? (q.clock_output_pin ^ d.sys_tick) : 1'b0;
        d.sys_en = sys_run;
        d.cpu_en = (q.pw == pllcg_pkg::PW_RUN);
        d.per_en = sys_run && main_run;
        d.main_en = main_run;
        d.wdt_en = 1'b1;
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    // Reset holds every gate closed and the oscillator stopped
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_B) begin
            q <= '0;
            q.pll <= pllcg_pkg::PLL_RESET;
            q.processor_clock_control <= pllcg_pkg::PCC_RESET;
            q.pw <= pllcg_pkg::PW_OST;
            q.ost <= 16'(OST_CYCLES - 1);
            q.sub_cnt <= 16'(SUB_CYCLES - 1);
        end else begin
            q <= d;
        end
    end

    // Outputs from flip-flops; subclock oscillator enable tied high
    assign O_RDATA = q.rdata;
    assign O_CPU_CLK_EN = q.cpu_en;
    assign O_SYS_CLK_EN = q.sys_en;
    assign O_PERIPH_CLK_EN = q.per_en;
    assign O_MAIN_OSC_EN = q.main_en;
    assign O_SUB_OSC_EN = 1'b1;
    assign O_WDT_INT_CLK_EN = q.wdt_en;
    assign O_PLL_EN = q.pll[pllcg_pkg::PLL_RUN_POS];
    assign O_FEEDBACK_OFF = q.processor_clock_control[pllcg_pkg::MAIN_FEEDBACK_RESISTOR_OFF_POS];
    assign O_SYS_TICK = q.sys_tick;
    assign O_CLOCK_OUTPUT_PIN = q.clock_output_pin;
    assign O_CLOCK_OUTPUT_PIN_OE_B = !q.port_fn;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_stop_wake;
        q.pw == pllcg_pkg::PW_STOP ##1 q.pw == pllcg_pkg::PW_OST;
    endsequence
    sequence s_sleep;
        !sys_run ##1 1'b1;
    endsequence
    // PLL feeding the eight-way divider: one tick every eight cycles
    sequence s_pll_div8;
        q.sel_eff && main_run && sys_run && !cpu_clock_status_bit && q.processor_clock_control[2:0] == 3'h3;
    endsequence

    a_clock_output_pin_low_stop: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B) s_sleep |-> !O_CLOCK_OUTPUT_PIN)
        else $error("clock output not low while stopped");
    a_pin_float_default: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        $fell(O_CLOCK_OUTPUT_PIN_OE_B) |-> $past(I_WR) &&
            $past(I_ADDR) == pllcg_pkg::ADDR_PORT &&
            $past(I_WDATA[pllcg_pkg::PORT_CLOCK_OUTPUT_PIN_POS]))
        else $error("clock output driven before port set");
    a_pll_reset_value: assert property (
        @(posedge I_MCLK) !I_RST_B |=> O_PLL_EN && !q.sel_eff &&
            q.pll == pllcg_pkg::PLL_RESET)
        else $error("pll control reset value wrong");
    a_pll_fast_tick: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        O_SYS_TICK ##0 s_pll_div8 ##1 s_pll_div8 [*7] |=> O_SYS_TICK)
        else $error("pll mode missing a fast tick");
    a_switch_aligned: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        $changed(q.sel_eff) && $past(main_run) |-> $past(osc_tick))
        else $error("source switch off an oscillator edge");
    a_main_osc_stop: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        q.pw == pllcg_pkg::PW_STOP |=> !O_MAIN_OSC_EN)
        else $error("main oscillator runs in stop");
    a_cpu_gate_off: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        q.pw != pllcg_pkg::PW_RUN |=> !O_CPU_CLK_EN)
        else $error("cpu clock runs outside run mode");
    a_periph_gate_off: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        !main_run || !sys_run |=> !O_PERIPH_CLK_EN)
        else $error("prescaler clock runs while stopped");
    a_ost_counted: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B)
        s_stop_wake |-> (q.pw == pllcg_pkg::PW_OST) [*2])
        else $error("stabilisation count skipped");
    a_divider_default: assert property (
        @(posedge I_MCLK) !I_RST_B |=> q.processor_clock_control[2:0] == 3'h3 && !cpu_clock_status_bit)
        else $error("divider default not eight");
    a_wdt_clock_runs: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B) $past(I_RST_B) |->
            O_WDT_INT_CLK_EN)
        else $error("watchdog clock stopped after reset");
    a_sys_clock_gate: assert property (
        @(posedge I_MCLK) disable iff (!I_RST_B) O_SYS_TICK |-> O_SYS_CLK_EN)
        else $error("system tick while gated");
endmodule : pllcg_top
`default_nettype wire

// *** pllcg_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pllcg_tb_top;
    // Small counts keep the run short
    localparam int LOCK_T = 20;
    localparam int OST_T = 8;
    localparam int SUB_T = 8;
    localparam int WIN = 1024;
    logic clk;
    logic rst_b;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr_s;
    logic rd_s;
    logic wake;
    logic [7:0] rdata;
    logic cpu, sys, per, mosc, sosc, wdt, pll, fboff, tick, cko, cko_oe_b;
    logic [5:0] gates;
    logic [7:0] v;
    int fail_count;
    int check_count;
    int n_a;
    int n_b;
    int n_e;
    assign gates = {cpu, sys, per, mosc, wdt, sosc};

    pllcg_top #(.LOCK_CYC(LOCK_T), .OST_CYCLES(OST_T), .SUB_CYCLES(SUB_T))
    pllcg_top_inst (.I_MCLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .I_WAKE(wake),
        .O_RDATA(rdata), .O_CPU_CLK_EN(cpu), .O_SYS_CLK_EN(sys),
        .O_PERIPH_CLK_EN(per), .O_MAIN_OSC_EN(mosc), .O_SUB_OSC_EN(sosc),
        .O_WDT_INT_CLK_EN(wdt), .O_PLL_EN(pll), .O_FEEDBACK_OFF(fboff),
        .O_SYS_TICK(tick), .O_CLOCK_OUTPUT_PIN(cko), .O_CLOCK_OUTPUT_PIN_OE_B(cko_oe_b));

    // ------------------------------------------------------------
    // Clock and watchdog on the whole run
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("unexpected at %0t: run too long", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask : check
    // Ratios only: absolute tick rate is the designer's choice
    task automatic near(input int got, input int exp, input int tol,
                        input string what);
        check_count++;
        if (got > exp + tol || got < exp - tol || exp == 0) begin
            fail_count++;
            $display("unexpected at %0t: %s %0d/%0d", $time, what, got, exp);
        end
    endtask : near
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd_raw(input logic [2:0] a);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_raw
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        rd_raw(a);
        check(v, exp, "read");
    endtask : rd
    // Bounded poll of one register bit
    task automatic poll(input logic [2:0] a, input int b, input logic e);
        for (int k = 0; k < 60; k++) begin
            rd_raw(a);
            if (v[b] === e) return;
        end
        fail_count++;
        $display("unexpected at %0t: poll timed out", $time);
        complete_run();
    endtask : poll
    task automatic wait_cpu();
        for (int k = 0; k < 200; k++) begin
            @(posedge clk);
            #1;
            if (cpu === 1'b1) return;
        end
        fail_count++;
        $display("unexpected at %0t: no wake", $time);
        complete_run();
    endtask : wait_cpu
    // Ticks and pin edges over a fixed window
    task automatic count();
        logic last;
        n_a = 0;
        n_e = 0;
        last = cko;
        repeat (WIN) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1) n_a++;
            if (cko !== last) n_e++;
            last = cko;
        end
    endtask : count
    // Enter a standby mode, check gates, leave by the wake pin
    task automatic standby(input logic [7:0] m, input logic [5:0] exp);
        wr(pllcg_pkg::ADDR_MODE, m);
        repeat (8) @(posedge clk);
        #1;
        check(8'(gates), 8'(exp), "standby gates");
        if (exp[4] == 1'b0) check(8'(cko), 8'h00, "pin low");
        @(posedge clk);
        wake <= 1'b1;
        wait_cpu();
        @(posedge clk);
        wake <= 1'b0;
        // Let the wake synchroniser drain, or the next mode write is lost
        repeat (3) @(posedge clk);
    endtask : standby

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        check_count = 0;
        rst_b = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        wake = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        check(8'(gates), 8'h01, "reset gates");
        check(8'({cko_oe_b, cko, pll}), 8'h05, "reset pin");
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(8'(gates), 8'h07, "count gates");
        wait_cpu();
        check(8'(gates), 8'h3F, "run gates");
        rd(pllcg_pkg::ADDR_PLL, 8'h01);
        rd(pllcg_pkg::ADDR_PCC, 8'h03);
        for (int a = 5; a < 8; a++) rd(3'(a), 8'h00);
        check(8'(cko_oe_b), 8'h01, "pin floats");
        // Divider: /1 must tick eight times as often as /8
        count();
        n_b = n_a;
        wr(pllcg_pkg::ADDR_PCC, 8'h00);
        count();
        near(n_a, 8 * n_b, 8, "divider ratio");
        wr(pllcg_pkg::ADDR_PCC, 8'h06);
        rd(pllcg_pkg::ADDR_PCC, 8'h00);
        wr(pllcg_pkg::ADDR_PCC, 8'h03);
        wr(pllcg_pkg::ADDR_PORT, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check(8'(cko_oe_b), 8'h00, "pin drives");
        count();
        near(n_e, n_a, 2, "pin follows clock");
        n_b = n_a;
        // PLL off drops lock; on again, lock waits out its count
        wr(pllcg_pkg::ADDR_PLL, 8'h00);
        rd(pllcg_pkg::ADDR_STAT, 8'h00);
        wr(pllcg_pkg::ADDR_PLL, 8'hF1);
        rd(pllcg_pkg::ADDR_PLL, 8'h01);
        rd(pllcg_pkg::ADDR_STAT, 8'h00);
        poll(pllcg_pkg::ADDR_STAT, 0, 1'b1);
        wr(pllcg_pkg::ADDR_PLL, 8'h03);
        poll(pllcg_pkg::ADDR_STAT, 1, 1'b1);
        count();
        near(n_a, 4 * n_b, 4, "pll ratio");
        near(n_e, n_a, 2, "pin in pll mode");
        wr(pllcg_pkg::ADDR_PLL, 8'h01);
        poll(pllcg_pkg::ADDR_STAT, 1, 1'b0);
        repeat (8) @(posedge clk);
        wr(pllcg_pkg::ADDR_PLL, 8'h00);
        #1;
        check(8'(pll), 8'h00, "pll off");
        standby(8'h01, 6'h1F);
        standby(8'h02, 6'h07);
        standby(8'h03, 6'h03);
        // Subclock, main stop, sub-IDLE and back
        wr(pllcg_pkg::ADDR_PCC, 8'h0B);
        poll(pllcg_pkg::ADDR_PCC, pllcg_pkg::CLS_POS, 1'b1);
        repeat (4) @(posedge clk);
        check(8'(gates), 8'h3F, "sub gates");
        wr(pllcg_pkg::ADDR_PCC, 8'h6B);
        repeat (8) @(posedge clk);
        #1;
        check(8'(gates), 8'h33, "sub main stop");
        check(8'(fboff), 8'h01, "feedback off");
        rd(pllcg_pkg::ADDR_PCC, 8'h7B);
        rd(pllcg_pkg::ADDR_STAT, 8'h04);
        standby(8'h02, 6'h03);
        wr(pllcg_pkg::ADDR_PCC, 8'h0B);
        repeat (OST_T + 4) @(posedge clk);
        wr(pllcg_pkg::ADDR_PCC, 8'h03);
        poll(pllcg_pkg::ADDR_PCC, pllcg_pkg::CLS_POS, 1'b0);
        // Second reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(pllcg_pkg::ADDR_PLL, 8'h01);
        check(8'({cko_oe_b, pll}), 8'h03, "reset again");
        complete_run();
    end
endmodule : pllcg_tb_top
`default_nettype wire
